/* File: rtl/spi_master_slave_core.sv */
/*
  Byte-wide synchronous serial port, master or slave, with its registers.
  Assumes a single bus clock well above the serial clock in slave mode;
  pin inputs are raw and pass two flops here; pads resolve the enables.
*/
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [spi_core_pkg::ADDR_W-1:0] addr,
  input wire logic [spi_core_pkg::DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [spi_core_pkg::DATA_W-1:0] rdData,
  // interrupt request
  output logic irqReq,
  // select pin
  input wire logic ssIn,
  output logic ssOut,
  output logic select_output_enable,
  // serial clock pin
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  // master-out pin
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  // master-in pin
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe
);
  import spi_core_pkg::*;

  // =====================================================================
  // declarations
  xfer_state_t state;
  logic [DATA_W-1:0] ctrlOne, ctrlTwo, baud, statusWord;
  logic [DATA_W-1:0] txBuf, rxData, shiftReg, rxByte;
  logic [3:0] syncA, syncB;
  logic [12:0] cfgKey, cfgLast;
  logic [4:0] edgeCnt;
  logic txFull, doneFlag, faultFlag, latched, sckLevel, sckPrev;
  logic txArmed, doneArmed, faultArmed;
  logic portEnable, master, cpol, cpha, selOe, lsbFirst;
  logic faultEn, bidirEn, bidir_output_enable, ssSel, inBit, outBit;
  logic ctrlOneWr, ctrlTwoWr, baudWr, dataWr, statusRd, dataRd;
  logic faultEv, abort, halfTick, masterEdge, slaveEdge, edgeEv;
  logic oddEdge, latchEv, shiftEv, lastEdge, completion;
  logic masterLoad, slaveLoad, slaveStart, acceptWr, baudRun;

  // shift one bit in at the end chosen by bit order
  function automatic logic [DATA_W-1:0] shiftIn(
    input logic [DATA_W-1:0] cur,
    input logic bitIn,
    input logic lsbf
  );
    if (lsbf) begin
      shiftIn = {bitIn, cur[DATA_W-1:1]};
    end else begin
      shiftIn = {cur[DATA_W-2:0], bitIn};
    end
  endfunction

  // =====================================================================
  // control decode
  assign portEnable = ctrlOne[C1_PORT_EN];
  assign master = ctrlOne[C1_MASTER];
  assign cpol = ctrlOne[C1_CPOL];
  assign cpha = ctrlOne[C1_CPHA];
  assign selOe = ctrlOne[C1_SEL_OE];
  assign lsbFirst = ctrlOne[C1_LSB_FIRST];
  assign faultEn = ctrlTwo[C2_FAULT_EN];
  assign bidir_output_enable = ctrlTwo[C2_BIDIR_OE];
  assign bidirEn = ctrlTwo[C2_BIDIR_EN];
  assign ctrlOneWr = wrStrobe && addr == ADDR_CTRL_ONE;
  assign ctrlTwoWr = wrStrobe && addr == ADDR_CTRL_TWO;
  assign baudWr = wrStrobe && addr == ADDR_BAUD;
  assign dataWr = wrStrobe && addr == ADDR_DATA;
  assign statusRd = rdStrobe && addr == ADDR_STATUS;
  assign dataRd = rdStrobe && addr == ADDR_DATA;

  // =====================================================================
  // pin synchronisers, two flops before any use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= SYNC_RESET;
      syncB <= SYNC_RESET;
      sckPrev <= 1'b0;
    end else begin
      syncA <= {misoIn, mosiIn, sckIn, ssIn};
      syncB <= syncA;
      sckPrev <= syncB[PIN_SCK];
    end
  end

  assign ssSel = !syncB[PIN_SS];
  // bidirectional mode folds input onto the shared pin
  assign inBit = master ? (bidirEn ? syncB[PIN_MOSI] : syncB[PIN_MISO])
                        : (bidirEn ? syncB[PIN_MISO] : syncB[PIN_MOSI]);

  // =====================================================================
  // events
  // select seen low as master with fault detect and no select drive
  assign faultEv = portEnable && master && faultEn && !selOe && ssSel;
  assign cfgKey = {cpol, cpha, selOe, lsbFirst, faultEn, bidirEn,
                   bidirEn && bidir_output_enable, baud[BAUD_PRE_LSB +: 3],
                   baud[BAUD_SEL_LSB +: 3]};
  // master format change, fault, deselect or disable end a transfer at once
  assign abort = faultEv
    || (master && cfgKey != cfgLast)
    || (!master && state != IDLE && !ssSel)
    || !portEnable;
  assign masterEdge = master && state == XFER && halfTick;
  // a deselected slave ignores its clock input entirely
  assign slaveEdge = !master && state == XFER && ssSel
                     && syncB[PIN_SCK] != sckPrev;
  assign edgeEv = masterEdge || slaveEdge;
  assign oddEdge = !edgeCnt[0];
  // latch on odd edges with phase clear, on even edges with it set
  assign latchEv = edgeEv && (oddEdge != cpha);
  // with phase set the first edge only presents the first bit
  assign shiftEv = edgeEv && (oddEdge == cpha)
                   && !(cpha && edgeCnt == '0);
  assign lastEdge = edgeEv && edgeCnt == LAST_EDGE;
  // phase set leaves one shift for after the sixteenth edge
  assign rxByte = cpha ? shiftIn(shiftReg, latched, lsbFirst) : shiftReg;
  assign completion = state == TAIL && halfTick && !abort;
  assign acceptWr = dataWr && txArmed;
  assign masterLoad = portEnable && master && txFull && !abort
                      && (state == IDLE || completion);
  assign slaveLoad = portEnable && !master && txFull && state == IDLE
                     && !ssSel;
  assign slaveStart = portEnable && !master && state == IDLE && ssSel
                      && !abort;
  // the slave only times its trailing half period
  assign baudRun = master ? state != IDLE : state == TAIL;

  spi_baud_tick #(
    .PRE_W(3),
    .SEL_W(3),
    .CNT_W(11)
  ) u_baud (
    .clk(clk),
    .reset_n(reset_n),
    .run(baudRun),
    .preselect(baud[BAUD_PRE_LSB +: 3]),
    .select(baud[BAUD_SEL_LSB +: 3]),
    .halfTick(halfTick)
  );

  // =====================================================================
  // transfer sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= IDLE;
    end else if (abort) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE: begin
          // first edge waits one half period after the load
          if (masterLoad || slaveStart) begin
            state <= XFER;
          end
        end
        XFER: begin
          if (lastEdge) begin
            state <= TAIL;
          end
        end
        TAIL: begin
          if (completion) begin
            state <= masterLoad ? XFER : IDLE;
          end
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // edges seen in the current byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edgeCnt <= '0;
    end else if (state != XFER) begin
      edgeCnt <= '0;
    end else if (edgeEv) begin
      edgeCnt <= edgeCnt + 5'h01;
    end
  end

  // serial clock level, parked at polarity while idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sckLevel <= 1'b0;
    end else if (state == IDLE) begin
      sckLevel <= cpol;
    end else if (masterEdge) begin
      sckLevel <= !sckLevel;
    end
  end

  // input bit captured on latch edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latched <= 1'b0;
    end else if (latchEv) begin
      latched <= inBit;
    end
  end

  // shifter: eight shifts swap bytes with the far end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftReg <= '0;
    end else if (masterLoad || slaveLoad) begin
      shiftReg <= txBuf;
    end else if (completion) begin
      shiftReg <= rxByte;
    end else if (shiftEv) begin
      shiftReg <= shiftIn(shiftReg, latched, lsbFirst);
    end
  end

  // =====================================================================
  // transmit buffer; empty flag is its inverse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txBuf <= '0;
      txFull <= 1'b0;
    end else if (acceptWr) begin
      txBuf <= wrData;
      txFull <= 1'b1;
    end else if (masterLoad || slaveLoad) begin
      txFull <= 1'b0;
    end
  end

  // read-then-access arming; a status read sees the flag set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txArmed <= 1'b0;
      doneArmed <= 1'b0;
      faultArmed <= 1'b0;
    end else begin
      if (statusRd && !txFull) begin
        txArmed <= 1'b1;
      end else if (dataWr) begin
        txArmed <= 1'b0;
      end
      if (statusRd && doneFlag) begin
        doneArmed <= 1'b1;
      end else if (dataRd) begin
        doneArmed <= 1'b0;
      end
      if (statusRd && faultFlag) begin
        faultArmed <= 1'b1;
      end else if (ctrlOneWr) begin
        faultArmed <= 1'b0;
      end
    end
  end

  // done flag and receive data; late bytes are dropped while set,
  // but a clearing read in the same cycle lets the new byte in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      doneFlag <= 1'b0;
      rxData <= '0;
    end else if (completion && (!doneFlag || (dataRd && doneArmed))) begin
      doneFlag <= 1'b1;
      rxData <= rxByte;
    end else if (dataRd && doneArmed && !completion) begin
      doneFlag <= 1'b0;
    end
  end

  // fault flag, set wins over the clearing write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      faultFlag <= 1'b0;
    end else if (faultEv) begin
      faultFlag <= 1'b1;
    end else if (ctrlOneWr && faultArmed) begin
      faultFlag <= 1'b0;
    end
  end

  // =====================================================================
  // control registers; a fault overrides a same-cycle master write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlOne <= CTRL_ONE_RESET;
    end else begin
      if (ctrlOneWr) begin
        ctrlOne <= wrData;
      end
      if (faultEv) begin
        ctrlOne[C1_MASTER] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlTwo <= CTRL_TWO_RESET;
      baud <= BAUD_RESET;
    end else begin
      if (ctrlTwoWr) begin
        ctrlTwo <= wrData & CTRL_TWO_MASK;
      end
      if (baudWr) begin
        baud <= wrData & BAUD_MASK;
      end
    end
  end

  // previous format, compared to spot a change
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgLast <= CFG_KEY_RESET;
    end else begin
      cfgLast <= cfgKey;
    end
  end

  // status image, unused bits read zero
  always_comb begin
    statusWord = '0;
    statusWord[ST_DONE] = doneFlag;
    statusWord[ST_TX_EMPTY] = !txFull;
    statusWord[ST_FAULT] = faultFlag;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= '0;
    end else if (!rdStrobe) begin
      rdData <= '0;
    end else begin
      case (addr)
        ADDR_CTRL_ONE: rdData <= ctrlOne;
        ADDR_CTRL_TWO: rdData <= ctrlTwo;
        ADDR_BAUD: rdData <= baud;
        ADDR_STATUS: rdData <= statusWord;
        ADDR_DATA: rdData <= rxData;
        default: rdData <= '0;
      endcase
    end
  end

  // =====================================================================
  // pins; all released while the port is disabled
  assign outBit = lsbFirst ? shiftReg[0] : shiftReg[DATA_W-1];
  assign irqReq = ctrlOne[C1_IRQ_EN] && (faultFlag || doneFlag);
  assign sckOut = sckLevel;
  assign sckOe = portEnable && master;
  assign mosiOut = outBit;
  assign mosiOe = portEnable && master && (!bidirEn || bidir_output_enable);
  assign misoOut = outBit;
  // phase clear: first bit stands as soon as select falls
  // a pending fault keeps the slave output off until it is cleared
  assign misoOe = portEnable && !master && ssSel && !faultFlag
                  && (!bidirEn || bidir_output_enable);
  assign ssOut = state == IDLE;
  assign select_output_enable = portEnable && master && faultEn && selOe;

  // =====================================================================
  // checks
  a_done_sets: assert property (@(posedge clk) disable iff (!reset_n)
    completion && !doneFlag |=> doneFlag && rxData == $past(rxByte))
    else $error("done flag or data not captured");
  a_done_clears: assert property (@(posedge clk) disable iff (!reset_n)
    dataRd && doneArmed && !completion |=> !doneFlag)
    else $error("done flag not cleared");
  a_write_ignored: assert property (@(posedge clk) disable iff (!reset_n)
    dataWr && !txArmed && !txFull |=> !txFull)
    else $error("unarmed data write accepted");
  a_fault_effect: assert property (@(posedge clk) disable iff (!reset_n)
    faultEv |=> faultFlag && !master && state == IDLE && !sckOe && !misoOe)
    else $error("fault did not take effect");
  a_fault_clear: assert property (@(posedge clk) disable iff (!reset_n)
    ctrlOneWr && faultArmed && !faultEv |=> !faultFlag)
    else $error("fault flag not cleared");
  a_pins_released: assert property (@(posedge clk) disable iff (!reset_n)
    !portEnable |-> !sckOe && !mosiOe && !misoOe && !select_output_enable)
    else $error("pin driven while disabled");
  a_start_delay: assert property (@(posedge clk) disable iff (!reset_n)
    state == IDLE && masterLoad |=> sckOut == $past(cpol) && edgeCnt == '0)
    else $error("clock started without delay");
  a_back_to_back: assert property (@(posedge clk) disable iff (!reset_n)
    completion && masterLoad |=> state == XFER && !txFull)
    else $error("queued byte not sent next");
  a_slave_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !master && !ssSel |-> !misoOe ##1 !(slaveEdge))
    else $error("deselected slave active");
  a_select_low: assert property (@(posedge clk) disable iff (!reset_n)
    lastEdge && !abort |=> !ssOut && state == TAIL)
    else $error("select or tail wrong");
endmodule
`default_nettype wire

/* File: rtl/spi_core_pkg.sv */
/*
  Constants, register map and state type shared by the serial port core
  and its test bench.
  Assumes a single bus clock and a byte-wide register port.
*/
// Notes on behaviour
// - done flag sets when received byte lands
// - done clears by status read, then data read
// - tx empty clears on status read, data write
// - data write without prior empty read ignored
// - select low while master sets fault flag
// - fault clears by status read, control write
// - queued master byte sent right after previous
// - unserviced done flag discards later bytes
// - enable bit hands four pins to port
// - transfer exchanges two bytes over eight shifts
// - master bit picks mode; only master starts
// - master data write loads shifter and starts
// - master drives select low during transfer
// - fault drops master, outputs, aborts transfer
// - fault flag with enable requests interrupt
// - half serial period before first clock edge
// - master format change aborts to idle
// - slave select rising forces slave idle
// - deselected slave tristates, ignores clock
// - phase bit picks latch and shift edges
// - slave first bit timing, store after eight
// - done flag half period after final edge
// - all-zero baud bits divide clock by two
package spi_core_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  // =====================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_BAUD = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h5;

  // =====================================================================
  // field positions
  localparam int C1_IRQ_EN = 7;
  localparam int C1_PORT_EN = 6;
  localparam int C1_MASTER = 4;
  localparam int C1_CPOL = 3;
  localparam int C1_CPHA = 2;
  localparam int C1_SEL_OE = 1;
  localparam int C1_LSB_FIRST = 0;
  localparam int C2_FAULT_EN = 4;
  localparam int C2_BIDIR_OE = 3;
  localparam int C2_BIDIR_EN = 0;
  localparam int ST_DONE = 7;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_FAULT = 4;
  localparam int BAUD_PRE_LSB = 4;
  localparam int BAUD_SEL_LSB = 0;
  localparam int PIN_SS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 3;

  // =====================================================================
  // reset values, masks, counts
  localparam logic [DATA_W-1:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BAUD_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_TWO_MASK = 8'h19;
  localparam logic [DATA_W-1:0] BAUD_MASK = 8'h77;
  localparam logic [3:0] SYNC_RESET = 4'h1;
  localparam logic [12:0] CFG_KEY_RESET = 13'h0000;
  localparam logic [4:0] LAST_EDGE = 5'h0f;

  typedef enum logic [1:0] {IDLE, XFER, TAIL} xfer_state_t;
endpackage

/* File: rtl/spi_baud_tick.sv */
/*
  Half-period tick generator for the serial clock.
  Assumes run is a level from the same clock; the count restarts when
  run drops, so the first tick comes one half period after run rises.
*/
`timescale 1ns/1ns
`default_nettype none
module spi_baud_tick #(
  parameter int PRE_W = 3,
  parameter int SEL_W = 3,
  parameter int CNT_W = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [PRE_W-1:0] preselect,
  input wire logic [SEL_W-1:0] select,
  // tick out
  output logic halfTick
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] halfLen;

  // the widest half period must fit the counter
  if (CNT_W < PRE_W + (1 << SEL_W)) begin : g_bad_width
    $error("spi_baud_tick: counter too narrow");
  end

  // half period is (pre + 1) * 2^sel, the full divisor halved
  assign halfLen = (CNT_W'(preselect) + CNT_W'(1)) << select;
  assign halfTick = run && (count == halfLen - CNT_W'(1));

  // free count while running, wraps on each tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (!run || halfTick) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

/* File: testbench/spi_slave_model.sv */
/*
  Behavioural serial slave standing on the far side of the port, mode 0.
  Assumes the port as master drives select, clock and master-out.
*/
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model #(
  parameter logic [7:0] FIRST_REPLY = 8'h3c
) (
  // serial pins
  input wire logic ssN,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // observation
  output logic [7:0] lastRx,
  output int numBytes
);
  logic [7:0] shifter = FIRST_REPLY;
  logic held = 1'b0;
  int bitCount = 0;
  // =====================================================================
  // pins and shifting
  initial begin
    lastRx = 8'h00;
    numBytes = 0;
  end
  // deselected line shows the inverse so a stale bit never passes
  assign miso = ssN ? ~shifter[7] : shifter[7];
  // latch on the rising edge while selected
  always @(posedge sck) begin
    if (!ssN) begin
      held = mosi;
    end
  end
  // shift on the falling edge, reply with the complement next time
  always @(negedge sck) begin
    if (!ssN) begin
      shifter = {shifter[6:0], held};
      bitCount = bitCount + 1;
      if (bitCount == 8) begin
        bitCount = 0;
        lastRx = shifter;
        numBytes = numBytes + 1;
        shifter = ~shifter;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/spi_master_slave_core_test.sv */
/*
  Self-checking bench for the serial port core, mostly in master mode.
  Assumes the core's register map and a behavioural slave on the pins.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin \
  numErrors++; $display("CHECK FAILED at %0t: got %h want %h", $time, \
  got, exp); end end
module spi_master_slave_core_test;
  import spi_core_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wrData = '0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic irqReq, ssOut, select_output_enable, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic tbSsN = 1'b1;
  logic pMiso;
  logic [7:0] pRx;
  logic [7:0] rv;
  int pBytes;
  int numErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int ssRise = 0;
  int r0;
  // =====================================================================
  // pin resolution; tbSsN high stands for the select pull-up
  wire logic ssW = select_output_enable ? ssOut : tbSsN;
  wire logic sckW = sckOe ? sckOut : 1'b0;
  wire logic mosiW = mosiOe ? mosiOut : ~mosiOut;
  wire logic misoW = misoOe ? misoOut : pMiso;
  spi_master_slave_core i_spi_master_slave_core (.clk(clk),
    .reset_n(reset_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .irqReq(irqReq), .ssIn(ssW),
    .ssOut(ssOut), .select_output_enable(select_output_enable), .sckIn(sckW), .sckOut(sckOut),
    .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe));
  spi_slave_model i_spi_slave_model (.ssN(ssW), .sck(sckW), .mosi(mosiW),
    .miso(pMiso), .lastRx(pRx), .numBytes(pBytes));
  // =====================================================================
  // clock, select edge count, watchdog
  always #10 clk = ~clk;
  always @(posedge ssW) ssRise++;
  // whole run is under 2000 cycles, so this only fires on a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      numErrors++;
      finishTest();
    end
  end
  // =====================================================================
  // bus tasks
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    @(negedge clk);
    d = rdData;
  endtask
  // status read that sees tx empty arms the data write
  task automatic send(input logic [7:0] d);
    int k;
    k = 0;
    rd(ADDR_STATUS, rv);
    while (rv[ST_TX_EMPTY] !== 1'b1 && k < 100) begin
      rd(ADDR_STATUS, rv);
      k++;
    end
    wr(ADDR_DATA, d);
  endtask
  task automatic waitDone();
    int k;
    k = 0;
    rd(ADDR_STATUS, rv);
    while (rv[ST_DONE] !== 1'b1 && k < 200) begin
      rd(ADDR_STATUS, rv);
      k++;
    end
    `CHK(rv[ST_DONE], 1'b1)
  endtask
  task automatic finishTest();
    $display("checks %0d, mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // =====================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    wr(ADDR_DATA, 8'h77);
    rd(ADDR_STATUS, rv);
    `CHK(rv, 8'h20)
    rd(3'h7, rv);
    `CHK(rv, 8'h00)
    `CHK(({select_output_enable, sckOe, mosiOe, misoOe}), 4'h0)
    $display("test reset done");
    // single transfer, half period of four bus clocks
    wr(ADDR_CTRL_TWO, 8'h10);
    wr(ADDR_BAUD, 8'h02);
    wr(ADDR_CTRL_ONE, 8'h52);
    repeat (2) @(posedge clk);
    `CHK(({select_output_enable, sckOe, mosiOe, misoOe}), 4'he)
    send(8'ha5);
    repeat (30) @(posedge clk);
    `CHK(ssW, 1'b0)
    repeat (30) @(posedge clk);
    rd(ADDR_STATUS, rv);
    `CHK(rv[ST_DONE], 1'b0)
    waitDone();
    rd(ADDR_DATA, rv);
    `CHK(rv, 8'h3c)
    `CHK(pRx, 8'ha5)
    rd(ADDR_STATUS, rv);
    `CHK(rv[ST_DONE], 1'b0)
    `CHK(ssW, 1'b1)
    $display("test single done");
    // queued byte follows at once; second result is lost unserviced
    r0 = ssRise;
    send(8'h96);
    send(8'h0f);
    waitDone();
    repeat (120) @(posedge clk);
    `CHK(pBytes, 3)
    `CHK(ssRise - r0, 1)
    rd(ADDR_DATA, rv);
    `CHK(rv, 8'h5a)
    `CHK(pRx, 8'h0f)
    $display("test queue done");
    // lsb first against the msb-first model reverses both bytes
    wr(ADDR_CTRL_ONE, 8'h53);
    send(8'h01);
    waitDone();
    rd(ADDR_DATA, rv);
    `CHK(rv, 8'h0f)
    `CHK(pRx, 8'h80)
    wr(ADDR_CTRL_ONE, 8'h52);
    $display("test order done");
    // baud change mid-transfer aborts; slave model is left stale
    send(8'h11);
    repeat (20) @(posedge clk);
    `CHK(ssW, 1'b0)
    wr(ADDR_BAUD, 8'h03);
    repeat (3) @(posedge clk);
    `CHK(ssW, 1'b1)
    repeat (150) @(posedge clk);
    rd(ADDR_STATUS, rv);
    `CHK(rv[ST_DONE], 1'b0)
    $display("test abort done");
    // another master pulls select low
    wr(ADDR_CTRL_ONE, 8'hd0);
    tbSsN <= 1'b0;
    repeat (5) @(posedge clk);
    rd(ADDR_STATUS, rv);
    `CHK(rv, 8'h30)
    `CHK(irqReq, 1'b1)
    rd(ADDR_CTRL_ONE, rv);
    `CHK(rv, 8'hc0)
    `CHK(({select_output_enable, sckOe, mosiOe, misoOe}), 4'h0)
    @(posedge clk);
    tbSsN <= 1'b1;
    rd(ADDR_STATUS, rv);
    wr(ADDR_CTRL_ONE, 8'h40);
    rd(ADDR_STATUS, rv);
    `CHK(rv, 8'h20)
    `CHK(irqReq, 1'b0)
    $display("test fault done");
    // slave output follows select; format bits left alone
    repeat (4) @(posedge clk);
    `CHK(misoOe, 1'b0)
    tbSsN <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(misoOe, 1'b1)
    tbSsN <= 1'b1;
    $display("test select done");
    finishTest();
  end
endmodule
`default_nettype wire
